/* hdl/pis_interrupt_status_regs.sv */
// Notes on behaviour
// - Problem flag bit 7 on fault causes
// - Flags read one; write one clears
// - Power-off flag bit 3 on shutdown
// - Power-off flag clears only after cause
// - Hot die flag bit 0 on hot
// - Mask register at 3h resets FFh
// - Mask bits 7,3,0 gate matching flags
// - Mask bit 0 only gates hot die
// - Status bit 0 live, others zero
// - Live bit one while above threshold
// - Identification: revision, variant, part fields
// - Rail good state at B0h, B1h
// - Rail problem state at B2h, B3h
`timescale 1ns/1ps
`include "pis_params.svh"
module pis_interrupt_status_regs
   import pis_pkg::*;
#(
   parameter logic [1:0] REVISION = 2'h2, // Arbitrary value
   parameter logic [1:0] VARIANT  = 2'h2, // Arbitrary value
   parameter logic [3:0] PART     = 4'hA  // Arbitrary value
)(
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        reg_rd_in,
   input  wire logic        reg_wr_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   output logic      [7:0]  reg_rdata_out,
   input  wire logic        undervoltage_in,
   input  wire logic        rail_problem_in,
   input  wire logic        critical_threshold_in,
   input  wire logic        power_off_in,
   input  wire logic        hot_die_in,
   input  wire logic        cold_off_in,
   input  wire logic [15:0] rail_good_in,
   input  wire logic [15:0] rail_problem_state_in,
   output logic             irq_drive_low_out,
   output logic             irq_pin_out
);

   // ****************************************************************
   // Access decode
   // ****************************************************************
   pis_acc_t acc;
   logic     wr_flags;
   logic     wr_masks;
   logic     wr_cause;

   always_comb begin
      acc = PIS_ACC_IDLE;
      if (reg_wr_in) begin
         acc = PIS_ACC_WRITE;
      end else if (reg_rd_in) begin
         acc = PIS_ACC_READ;
      end
   end

   assign wr_flags = (acc == PIS_ACC_WRITE)
                     && (reg_addr_in == `PIS_OFS_FLAGS);
   assign wr_masks = (acc == PIS_ACC_WRITE)
                     && (reg_addr_in == `PIS_OFS_MASKS);
   assign wr_cause = (acc == PIS_ACC_WRITE)
                     && (reg_addr_in == `PIS_OFS_CAUSE);

   // ****************************************************************
   // Power-off cause bits, write one to clear
   // ****************************************************************
   logic [3:0] cause;
   logic [3:0] next_cause;
   logic [3:0] cause_set;

   assign cause_set = {cold_off_in, undervoltage_in & power_off_in,
                       rail_problem_in & power_off_in,
                       critical_threshold_in & power_off_in};

   always_comb begin
      next_cause = cause;
      if (wr_cause) begin
         next_cause = cause & ~reg_wdata_in[3:0];
      end
      next_cause = next_cause | cause_set;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cause <= `PIS_RST_CAUSE;
      end else begin
         cause <= next_cause;
      end
   end

   // ****************************************************************
   // Sticky interrupt flags
   // ****************************************************************
   localparam int NFLAG = 3;
   localparam int FLAG_POS [NFLAG] = '{`PIS_BIT_PROBLEM,
                                       `PIS_BIT_POWER_OFF,
                                       `PIS_BIT_HOT_DIE};
   logic [NFLAG-1:0] flag_set;
   logic [NFLAG-1:0] flag_ok;
   logic [NFLAG-1:0] flag_val;

   assign flag_set[0] = undervoltage_in | rail_problem_in
                        | critical_threshold_in;
   assign flag_set[1] = power_off_in;
   assign flag_set[2] = hot_die_in;
   assign flag_ok[0]  = 1'b1;
   assign flag_ok[1]  = (cause == 4'h0);
   assign flag_ok[2]  = 1'b1;

   genvar gi;
   generate
      for (gi = 0; gi < NFLAG; gi++) begin : g_flag
         pis_flag_if fl ();
         assign fl.set_hit     = flag_set[gi];
         assign fl.clr_hit     = wr_flags
                                 && reg_wdata_in[FLAG_POS[gi]];
         assign fl.clr_allowed = flag_ok[gi];
         assign flag_val[gi]   = fl.flag;
         pis_sticky_flag u_flag (
            .clk_in   (clk_in),
            .rst_b_in (rst_b_in),
            .fl       (fl)
         );
      end
   endgenerate

   logic [7:0] flags_byte;
   always_comb begin
      flags_byte = `PIS_RST_FLAGS;
      flags_byte[`PIS_BIT_PROBLEM]   = flag_val[0];
      flags_byte[`PIS_BIT_POWER_OFF] = flag_val[1];
      flags_byte[`PIS_BIT_HOT_DIE]   = flag_val[2];
   end

   // ****************************************************************
   // Mask register
   // ****************************************************************
   logic [7:0] masks;
   logic [7:0] next_masks;

   always_comb begin
      next_masks = masks;
      if (wr_masks) begin
         next_masks = (reg_wdata_in & ~`PIS_MASK_FIXED)
                      | `PIS_MASK_FIXED;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         masks <= `PIS_RST_MASKS;
      end else begin
         masks <= next_masks;
      end
   end

   // ****************************************************************
   // Interrupt pin, open drain
   // ****************************************************************
   logic irq_live;
   logic next_irq;
   logic irq;

   assign irq_live = |(flags_byte & ~masks);
   always_comb begin
      next_irq = irq_live;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   assign irq_drive_low_out = irq;
   assign irq_pin_out       = 1'b0;

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [7:0] rdata;
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = rdata;
      if (acc == PIS_ACC_READ) begin
         unique case (reg_addr_in)
            `PIS_OFS_IDENT: begin
               next_rdata = {REVISION, VARIANT, PART};
            end
            `PIS_OFS_FLAGS: begin
               next_rdata = flags_byte;
            end
            `PIS_OFS_MASKS: begin
               next_rdata = masks;
            end
            `PIS_OFS_TEMP_STAT: begin
               next_rdata = {7'h00, hot_die_in};
            end
            `PIS_OFS_CAUSE: begin
               next_rdata = {4'h0, cause};
            end
            `PIS_OFS_GOOD_A: begin
               next_rdata = rail_good_in[7:0];
            end
            `PIS_OFS_GOOD_B: begin
               next_rdata = rail_good_in[15:8];
            end
            `PIS_OFS_PROB_A: begin
               next_rdata = rail_problem_state_in[7:0];
            end
            `PIS_OFS_PROB_B: begin
               next_rdata = rail_problem_state_in[15:8];
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign reg_rdata_out = rdata;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_mask_reset;
      @(posedge clk_in) $rose(rst_b_in) |-> masks == 8'hFF;
   endproperty
   a_mask_reset: assert property (p_mask_reset)
      else $error("mask not FF after reset");

   property p_irq_follow;
      @(posedge clk_in) disable iff (!rst_b_in)
      irq_live |=> irq_drive_low_out;
   endproperty
   a_irq_follow: assert property (p_irq_follow)
      else $error("interrupt not driven");

   property p_irq_release;
      @(posedge clk_in) disable iff (!rst_b_in)
      !irq_live |=> !irq_drive_low_out;
   endproperty
   a_irq_release: assert property (p_irq_release)
      else $error("interrupt not released");

   property p_problem_set;
      @(posedge clk_in) disable iff (!rst_b_in)
      (undervoltage_in || rail_problem_in || critical_threshold_in)
      |=> flags_byte[7];
   endproperty
   a_problem_set: assert property (p_problem_set)
      else $error("problem flag not set");

   property p_off_set;
      @(posedge clk_in) disable iff (!rst_b_in)
      power_off_in |=> flags_byte[3];
   endproperty
   a_off_set: assert property (p_off_set)
      else $error("power-off flag not set");

   property p_hot_set;
      @(posedge clk_in) disable iff (!rst_b_in)
      hot_die_in |=> flags_byte[0];
   endproperty
   a_hot_set: assert property (p_hot_set)
      else $error("hot die flag not set");

   property p_off_guard;
      @(posedge clk_in) disable iff (!rst_b_in)
      (flags_byte[3] && cause != 4'h0) |=> flags_byte[3];
   endproperty
   a_off_guard: assert property (p_off_guard)
      else $error("power-off flag cleared early");

   property p_live_read;
      @(posedge clk_in) disable iff (!rst_b_in)
      (reg_rd_in && !reg_wr_in && reg_addr_in == 8'h04)
      |=> reg_rdata_out == {7'h00, $past(hot_die_in)};
   endproperty
   a_live_read: assert property (p_live_read)
      else $error("live status read wrong");
endmodule : pis_interrupt_status_regs

/* hdl/pis_params.svh */
`ifndef PIS_PARAMS_SVH
`define PIS_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PIS_OFS_IDENT      8'h01
`define PIS_OFS_FLAGS      8'h02
`define PIS_OFS_MASKS      8'h03
`define PIS_OFS_TEMP_STAT  8'h04
`define PIS_OFS_CAUSE      8'h05
`define PIS_OFS_GOOD_A     8'hB0
`define PIS_OFS_GOOD_B     8'hB1
`define PIS_OFS_PROB_A     8'hB2
`define PIS_OFS_PROB_B     8'hB3

// ****************************************************************
// Field positions
// ****************************************************************
`define PIS_BIT_PROBLEM    7
`define PIS_BIT_POWER_OFF  3
`define PIS_BIT_HOT_DIE    0
`define PIS_BIT_HOT_LIVE   0

// ****************************************************************
// Reset values and fixed mask bits
// ****************************************************************
`define PIS_RST_FLAGS      8'h00
`define PIS_RST_MASKS      8'hFF
`define PIS_RST_CAUSE      4'h0
`define PIS_MASK_FIXED     8'h76

`endif

/* hdl/pis_pkg.sv */
package pis_pkg;

   // Host register bus access kinds
   typedef enum logic [1:0] {
      PIS_ACC_IDLE  = 2'b00,
      PIS_ACC_READ  = 2'b01,
      PIS_ACC_WRITE = 2'b11
   } pis_acc_t;

   typedef logic [7:0] pis_byte_t;

endpackage : pis_pkg

/* hdl/pis_flag_if.sv */
`timescale 1ns/1ps
interface pis_flag_if;
   logic set_hit;
   logic clr_hit;
   logic clr_allowed;
   logic flag;
   modport owner (input set_hit, input clr_hit, input clr_allowed,
                  output flag);
   modport user  (output set_hit, output clr_hit, output clr_allowed,
                  input flag);
endinterface : pis_flag_if

/* hdl/pis_sticky_flag.sv */
`timescale 1ns/1ps
module pis_sticky_flag
   import pis_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   pis_flag_if.owner fl
);
   logic flag;
   logic next_flag;

   // Set beats a clear in the same cycle
   always_comb begin
      next_flag = flag;
      if (fl.clr_hit && fl.clr_allowed) begin
         next_flag = 1'b0;
      end
      if (fl.set_hit) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end

   assign fl.flag = flag;

   property p_set_wins;
      @(posedge clk_in) disable iff (!rst_b_in)
      fl.set_hit |=> flag;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("flag not set after event");

   property p_hold;
      @(posedge clk_in) disable iff (!rst_b_in)
      (flag && !(fl.clr_hit && fl.clr_allowed)) |=> flag;
   endproperty
   a_hold: assert property (p_hold)
      else $error("flag dropped without clear");
endmodule : pis_sticky_flag

/* verif/pis_host_model.sv */
`timescale 1ns/1ps
module pis_host_model
   import pis_pkg::*;
(
   input  wire logic       clk_in,
   output logic            reg_rd_out,
   output logic            reg_wr_out,
   output pis_byte_t       reg_addr_out,
   output pis_byte_t       reg_wdata_out
);
   // Idle cycles after each access, zero for back to back
   int unsigned idle = 0;

   initial begin
      reg_rd_out    = 1'b0;
      reg_wr_out    = 1'b0;
      reg_addr_out  = 8'h00;
      reg_wdata_out = 8'h00;
   end

   // Released lines show the inverse so stale values are never trusted
   task automatic rd_reg(input pis_byte_t a);
      @(posedge clk_in);
      reg_rd_out   <= 1'b1;
      reg_addr_out <= a;
      @(posedge clk_in);
      reg_rd_out   <= 1'b0;
      reg_addr_out <= ~a;
      repeat (idle) @(posedge clk_in);
   endtask : rd_reg

   task automatic wr_reg(input pis_byte_t a, input pis_byte_t d);
      @(posedge clk_in);
      reg_wr_out    <= 1'b1;
      reg_addr_out  <= a;
      reg_wdata_out <= d;
      @(posedge clk_in);
      reg_wr_out    <= 1'b0;
      reg_addr_out  <= ~a;
      reg_wdata_out <= ~d;
      repeat (idle) @(posedge clk_in);
   endtask : wr_reg
endmodule : pis_host_model

/* verif/test_pis_interrupt_status_regs.sv */
`timescale 1ns/1ps
module test_pis_interrupt_status_regs
   import pis_pkg::*;
;
   // Arbitrary identification fields
   localparam logic [7:0] IDENT = 8'hB6;
   logic        clk_in, rst_b_in, rd, wr, uv, rp, ct, po, hot, cold;
   pis_byte_t   addr, wdata, rdata, pick;
   logic [15:0] good, prob;
   logic        irq_low, irq_pin;
   int          errors = 0, check_count = 0;
   int          m_flags, m_masks, m_cause, m_rdata, m_irq;
   pis_byte_t   offs [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                              8'h06, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hFF};

   pis_host_model host (.clk_in(clk_in), .reg_rd_out(rd), .reg_wr_out(wr),
      .reg_addr_out(addr), .reg_wdata_out(wdata));
   pis_interrupt_status_regs #(.REVISION(2'h2), .VARIANT(2'h3),
      .PART(4'h6)) DUT (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .reg_rd_in(rd), .reg_wr_in(wr), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .undervoltage_in(uv),
      .rail_problem_in(rp), .critical_threshold_in(ct),
      .power_off_in(po), .hot_die_in(hot), .cold_off_in(cold),
      .rail_good_in(good), .rail_problem_state_in(prob),
      .irq_drive_low_out(irq_low), .irq_pin_out(irq_pin));

   always #50 clk_in = ~clk_in;

   // ****************************************************************
   // Reference model
   // ****************************************************************
   always @(posedge clk_in or negedge rst_b_in) begin : ref_model
      int f, c, v;
      if (!rst_b_in) begin
         m_flags = 0; m_masks = 'hFF; m_cause = 0; m_rdata = 0; m_irq = 0;
      end else begin
         m_irq = ((m_flags & ~m_masks & 'h89) != 0);
         case (addr)
            8'h01: v = IDENT;
            8'h02: v = m_flags;
            8'h03: v = m_masks;
            8'h04: v = hot;
            8'h05: v = m_cause;
            8'hB0: v = good[7:0];
            8'hB1: v = good[15:8];
            8'hB2: v = prob[7:0];
            8'hB3: v = prob[15:8];
            default: v = 0;
         endcase
         if (rd && !wr) m_rdata = v;
         f = m_flags;
         c = m_cause;
         // Power-off flag keeps its value while any cause bit stands
         if (wr && addr == 8'h02) begin
            f &= ~(wdata & ((c != 0) ? 'h81 : 'h89));
         end
         if (wr && addr == 8'h05) c &= ~(wdata & 'h0F);
         if (wr && addr == 8'h03) begin
            m_masks = (wdata & 'h89) | 'h76;
         end
         f |= ((uv | rp | ct) << 7);
         f |= (po << 3) | hot;
         c |= (cold << 3) | ((po & uv) << 2) | ((po & rp) << 1) | (po & ct);
         m_flags = f;
         m_cause = c;
      end
   end

   task automatic check(input logic [7:0] got, input int exp, input string s);
      check_count++;
      if (got !== exp[7:0]) begin
         errors++;
         $display("BAD %0t %s got %h want %h", $time, s, got, exp[7:0]);
      end
   endtask : check

   always @(negedge clk_in) begin
      if (rst_b_in) begin
         check(rdata, m_rdata, "read data");
         check({7'h00, irq_low}, m_irq, "irq enable");
         check({7'h00, irq_pin}, 0, "irq level");
      end
   end

   task automatic conclude;
      $display("Comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude

   initial begin
      #3000000;
      errors++;
      conclude();
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      clk_in = 1'b0; rst_b_in = 1'b0; {uv, rp, ct, po, hot, cold} = 6'h00;
      good = 16'h0000; prob = 16'h0000;
      void'($urandom(32'h4aaf));
      repeat (12) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      good <= 16'($urandom);
      prob <= 16'($urandom);
      foreach (offs[i]) host.rd_reg(offs[i]);
      host.wr_reg(8'h01, 8'hFF);
      host.wr_reg(8'h04, 8'hFF);
      foreach (offs[i]) host.rd_reg(offs[i]);
      $display("Test registers done");
      host.wr_reg(8'h03, 8'h00);
      hot <= 1'b1;
      host.rd_reg(8'h04);
      hot <= 1'b0;
      repeat (3) @(posedge clk_in);
      host.rd_reg(8'h02);
      host.wr_reg(8'h02, 8'h00);
      host.wr_reg(8'h02, 8'h01);
      host.rd_reg(8'h02);
      $display("Test hot die done");
      po <= 1'b1;
      rp <= 1'b1;
      @(posedge clk_in);
      po <= 1'b0;
      rp <= 1'b0;
      for (int a = 'hB2; a <= 'hB6; a++) host.rd_reg(a[7:0]);
      host.rd_reg(8'h05);
      host.wr_reg(8'h02, 8'h08);
      host.rd_reg(8'h02);
      host.wr_reg(8'h05, 8'h0F);
      host.wr_reg(8'h02, 8'h88);
      host.rd_reg(8'h02);
      $display("Test shutdown done");
      // Each other fault cause alone, then undervoltage, critical threshold and cold-off with a shutdown
      uv <= 1'b1;
      @(posedge clk_in);
      uv <= 1'b0;
      ct <= 1'b1;
      @(posedge clk_in);
      uv <= 1'b1;
      po <= 1'b1;
      cold <= 1'b1;
      @(posedge clk_in);
      uv <= 1'b0;
      ct <= 1'b0;
      po <= 1'b0;
      cold <= 1'b0;
      host.rd_reg(8'h05);
      host.rd_reg(8'h02);
      host.wr_reg(8'h02, 8'h88);
      host.rd_reg(8'h02);
      host.wr_reg(8'h05, 8'h0F);
      host.wr_reg(8'h02, 8'h08);
      host.rd_reg(8'h02);
      $display("Test causes done");
      rst_b_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      host.rd_reg(8'h03);
      host.rd_reg(8'h02);
      $display("Test reset done");
      for (int n = 0; n < 1500; n++) begin
         @(posedge clk_in);
         uv <= ($urandom % 16 == 0);
         rp <= ($urandom % 16 == 0);
         ct <= ($urandom % 16 == 0);
         po <= ($urandom % 16 == 0);
         hot <= ($urandom % 8 == 0);
         cold <= ($urandom % 16 == 0);
         good <= 16'($urandom);
         prob <= 16'($urandom);
         pick = offs[$urandom % 12];
         host.idle = $urandom % 3;
         if ($urandom % 2) host.wr_reg(pick, 8'($urandom));
         else host.rd_reg(pick);
      end
      $display("Test random done");
      conclude();
   end
endmodule : test_pis_interrupt_status_regs
